// ===== core/dms_sideband.sv
// Maintenance sideband: request and progress registers over AXI4-Lite,
// and a sequencer that turns requests into DRAM commands for the PHY.
// Assumes the PHY command port and auto power down state share aclk.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
module dms_sideband (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dms_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dms_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic phy_cmd_valid,
    output dms_pkg::dms_cmd_type phy_cmd_code,
    output logic [3:0] phy_cmd_rank,
    input wire logic phy_cmd_ready,
    input wire logic auto_pd_state
);
    // Bus and register state
    logic [5:0] aw_idx, next_aw_idx;
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic mr_go, next_mr_go, zq_long, next_zq_long, zq_short, next_zq_short;
    logic dpd_req, next_dpd_req;
    logic [3:0] ref_req, next_ref_req, sr_req, next_sr_req;
    logic [31:0] timing, next_timing;
    logic wr_fire;
    // Sequencer state
    dms_pkg::dms_state_type state, next_state;
    dms_pkg::dms_cmd_type next_cmd;
    logic next_cmd_valid;
    logic [3:0] next_rank;
    logic mr_busy, next_mr_busy, ref_ack, next_ref_ack, zq_ack, next_zq_ack;
    logic sr_ack, next_sr_ack, dpd_ack, next_dpd_ack, apd_ack;
    logic clr_mr, clr_zq_long, clr_zq_short;
    logic [3:0] clr_ref;

    dms_timer_if tmr ();

    dms_interval_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .tmr(tmr.timer)
    );

    function automatic logic is_mapped(input logic [5:0] idx);
        return (idx >= dms_pkg::IDX_MR_GO && idx <= dms_pkg::IDX_APD_PROGRESS)
            || idx == dms_pkg::IDX_TIMING;
    endfunction : is_mapped

    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Progress bits come only from sequencer state and auto_pd_state, never from writes
    function automatic logic [31:0] read_word(input logic [5:0] idx);
        logic [31:0] v;
        v = '0;
        if (idx == dms_pkg::IDX_MR_GO) begin
            v[0] = mr_go;
        end else if (idx == dms_pkg::IDX_REFRESH_REQ) begin
            v[3:0] = ref_req;
        end else if (idx == dms_pkg::IDX_ZQ_LONG) begin
            v[0] = zq_long;
        end else if (idx == dms_pkg::IDX_ZQ_SHORT) begin
            v[0] = zq_short;
        end else if (idx == dms_pkg::IDX_SELF_REFRESH) begin
            v[3:0] = sr_req;
        end else if (idx == dms_pkg::IDX_DEEP_PD) begin
            v[0] = dpd_req;
        end else if (idx == dms_pkg::IDX_MR_PROGRESS) begin
            v[0] = mr_busy;
        end else if (idx == dms_pkg::IDX_REF_PROGRESS) begin
            v[0] = ref_ack;
        end else if (idx == dms_pkg::IDX_ZQ_PROGRESS) begin
            v[0] = zq_ack;
        end else if (idx == dms_pkg::IDX_SR_PROGRESS) begin
            v[0] = sr_ack;
        end else if (idx == dms_pkg::IDX_DPD_PROGRESS) begin
            v[0] = dpd_ack;
        end else if (idx == dms_pkg::IDX_APD_PROGRESS) begin
            v[0] = apd_ack;
        end else if (idx == dms_pkg::IDX_TIMING) begin
            v = timing;
        end
        return v;
    endfunction : read_word

    assign wr_fire = aw_full && w_full && !s_axi_bvalid;

    // Bus slave and request registers; a software write lands after the
    // hardware clear so a set in the clearing cycle is never lost
    always_comb begin
        next_aw_idx = aw_idx;
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_mr_go = clr_mr ? 1'b0 : mr_go;
        next_zq_long = clr_zq_long ? 1'b0 : zq_long;
        next_zq_short = clr_zq_short ? 1'b0 : zq_short;
        next_ref_req = ref_req & ~clr_ref;
        next_sr_req = sr_req;
        next_dpd_req = dpd_req;
        next_timing = timing;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_idx = s_axi_awaddr[7:2];
            next_aw_full = 1'b1;
            next_awready = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
            next_w_full = 1'b1;
            next_wready = 1'b0;
        end
        if (wr_fire) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_idx) ? dms_pkg::RESP_OKAY : dms_pkg::RESP_DECERR;
            if (!w_strb[0]) begin
                // Byte lane 0 holds every request bit
            end else if (aw_idx == dms_pkg::IDX_MR_GO) begin
                next_mr_go = w_data[0];
            end else if (aw_idx == dms_pkg::IDX_REFRESH_REQ) begin
                next_ref_req = w_data[3:0];
            end else if (aw_idx == dms_pkg::IDX_ZQ_LONG) begin
                next_zq_long = w_data[0];
            end else if (aw_idx == dms_pkg::IDX_ZQ_SHORT) begin
                next_zq_short = w_data[0];
            end else if (aw_idx == dms_pkg::IDX_SELF_REFRESH) begin
                next_sr_req = w_data[3:0];
            end else if (aw_idx == dms_pkg::IDX_DEEP_PD) begin
                next_dpd_req = w_data[0];
            end
            // Progress indices fall through untouched
            if (aw_idx == dms_pkg::IDX_TIMING) begin
                next_timing = merge(timing, w_data, w_strb);
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rdata = read_word(s_axi_araddr[7:2]);
            next_rresp = is_mapped(s_axi_araddr[7:2]) ? dms_pkg::RESP_OKAY
                : dms_pkg::RESP_DECERR;
            next_rvalid = 1'b1;
            next_arready = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_idx <= '0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dms_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= dms_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
            mr_go <= 1'b0;
            zq_long <= 1'b0;
            zq_short <= 1'b0;
            ref_req <= dms_pkg::RANKS_NONE;
            sr_req <= dms_pkg::RANKS_NONE;
            dpd_req <= 1'b0;
            timing <= dms_pkg::TIMING_RESET;
        end else begin
            aw_idx <= next_aw_idx;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            mr_go <= next_mr_go;
            zq_long <= next_zq_long;
            zq_short <= next_zq_short;
            ref_req <= next_ref_req;
            sr_req <= next_sr_req;
            dpd_req <= next_dpd_req;
            timing <= next_timing;
        end
    end

    // Sequencer; a mixed self-refresh field neither enters nor leaves
    always_comb begin
        next_state = state;
        next_cmd = phy_cmd_code;
        next_cmd_valid = phy_cmd_valid;
        next_rank = phy_cmd_rank;
        next_mr_busy = mr_busy;
        next_ref_ack = ref_ack;
        next_zq_ack = zq_ack;
        next_sr_ack = sr_ack;
        next_dpd_ack = dpd_ack;
        clr_mr = 1'b0;
        clr_zq_long = 1'b0;
        clr_zq_short = 1'b0;
        clr_ref = dms_pkg::RANKS_NONE;
        tmr.start = 1'b0;
        tmr.length = timing[dms_pkg::REF_INTERVAL_LSB +: dms_pkg::TIME_W];
        case (state)
            dms_pkg::ST_IDLE: begin
                next_rank = dms_pkg::RANKS_ALL;
                next_state = dms_pkg::ST_ISSUE;
                next_cmd_valid = 1'b1;
                if (sr_req == dms_pkg::RANKS_ALL) begin
                    next_cmd = dms_pkg::CMD_SRE;
                end else if (dpd_req) begin
                    next_cmd = dms_pkg::CMD_DPDE;
                end else if (mr_go) begin
                    next_cmd = dms_pkg::CMD_MRS;
                    next_mr_busy = 1'b1;
                end else if (zq_long) begin
                    next_cmd = dms_pkg::CMD_ZQCL;
                end else if (zq_short) begin
                    next_cmd = dms_pkg::CMD_ZQCS;
                end else if (ref_req != dms_pkg::RANKS_NONE) begin
                    next_cmd = dms_pkg::CMD_REF;
                    next_rank = ref_req & (~ref_req + 4'h1);
                end else begin
                    next_state = dms_pkg::ST_IDLE;
                    next_cmd_valid = 1'b0;
                end
            end
            dms_pkg::ST_ISSUE: begin
                if (phy_cmd_ready) begin
                    next_cmd_valid = 1'b0;
                    next_state = dms_pkg::ST_WAIT;
                    case (phy_cmd_code)
                        dms_pkg::CMD_SRE: begin
                            next_sr_ack = 1'b1;
                            next_state = dms_pkg::ST_SELF_REFRESH;
                        end
                        dms_pkg::CMD_SRX: begin
                            next_sr_ack = 1'b0;
                            next_state = dms_pkg::ST_IDLE;
                        end
                        dms_pkg::CMD_DPDE: begin
                            next_dpd_ack = 1'b1;
                            next_state = dms_pkg::ST_DEEP_PD;
                        end
                        dms_pkg::CMD_DPDX: begin
                            next_dpd_ack = 1'b0;
                            next_state = dms_pkg::ST_IDLE;
                        end
                        dms_pkg::CMD_REF: begin
                            next_ref_ack = 1'b1;
                            tmr.start = 1'b1;
                        end
                        dms_pkg::CMD_ZQCL: begin
                            next_zq_ack = 1'b1;
                            tmr.start = 1'b1;
                            tmr.length = timing[dms_pkg::ZQ_LONG_LSB +: dms_pkg::TIME_W];
                        end
                        dms_pkg::CMD_ZQCS: begin
                            next_zq_ack = 1'b1;
                            tmr.start = 1'b1;
                            tmr.length = timing[dms_pkg::ZQ_SHORT_LSB +: dms_pkg::TIME_W];
                        end
                        default: begin
                            tmr.start = 1'b1;
                            tmr.length = timing[dms_pkg::MR_INTERVAL_LSB +: dms_pkg::TIME_W];
                        end
                    endcase
                end
            end
            dms_pkg::ST_WAIT: begin
                // Timer busy is already high on the first cycle here
                if (!tmr.busy) begin
                    next_state = dms_pkg::ST_IDLE;
                    next_ref_ack = 1'b0;
                    next_zq_ack = 1'b0;
                    next_mr_busy = 1'b0;
                    clr_mr = (phy_cmd_code == dms_pkg::CMD_MRS);
                    clr_zq_long = (phy_cmd_code == dms_pkg::CMD_ZQCL);
                    clr_zq_short = (phy_cmd_code == dms_pkg::CMD_ZQCS);
                    if (phy_cmd_code == dms_pkg::CMD_REF) begin
                        clr_ref = phy_cmd_rank;
                    end
                end
            end
            dms_pkg::ST_SELF_REFRESH: begin
                if (sr_req == dms_pkg::RANKS_NONE) begin
                    next_cmd = dms_pkg::CMD_SRX;
                    next_cmd_valid = 1'b1;
                    next_state = dms_pkg::ST_ISSUE;
                end
            end
            default: begin
                if (!dpd_req) begin
                    next_cmd = dms_pkg::CMD_DPDX;
                    next_cmd_valid = 1'b1;
                    next_state = dms_pkg::ST_ISSUE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= dms_pkg::ST_IDLE;
            phy_cmd_code <= dms_pkg::CMD_REF;
            phy_cmd_valid <= 1'b0;
            phy_cmd_rank <= dms_pkg::RANKS_NONE;
            mr_busy <= 1'b0;
            ref_ack <= 1'b0;
            zq_ack <= 1'b0;
            sr_ack <= 1'b0;
            dpd_ack <= 1'b0;
            apd_ack <= 1'b0;
        end else begin
            state <= next_state;
            phy_cmd_code <= next_cmd;
            phy_cmd_valid <= next_cmd_valid;
            phy_cmd_rank <= next_rank;
            mr_busy <= next_mr_busy;
            ref_ack <= next_ref_ack;
            zq_ack <= next_zq_ack;
            sr_ack <= next_sr_ack;
            dpd_ack <= next_dpd_ack;
            apd_ack <= auto_pd_state;
        end
    end

    // Checks on the sequencer and its progress bits
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    zq_long_issue_a: assert property (state == dms_pkg::ST_IDLE && zq_long && !mr_go
        && !dpd_req && sr_req != dms_pkg::RANKS_ALL |=> phy_cmd_valid
        && phy_cmd_code == dms_pkg::CMD_ZQCL) else $error("long cal not issued");
    zq_short_issue_a: assert property (state == dms_pkg::ST_IDLE && zq_short && !zq_long
        && !mr_go && !dpd_req && sr_req != dms_pkg::RANKS_ALL |=> phy_cmd_valid
        && phy_cmd_code == dms_pkg::CMD_ZQCS) else $error("short cal not issued");
    sr_hold_a: assert property (state == dms_pkg::ST_SELF_REFRESH
        && sr_req != dms_pkg::RANKS_NONE |=> state == dms_pkg::ST_SELF_REFRESH)
        else $error("self-refresh left early");
    dpd_exit_a: assert property (state == dms_pkg::ST_DEEP_PD && !dpd_req
        |=> phy_cmd_valid && phy_cmd_code == dms_pkg::CMD_DPDX)
        else $error("deep power down exit missing");
    sr_ack_state_a: assert property (sr_ack == (state == dms_pkg::ST_SELF_REFRESH
        || (state == dms_pkg::ST_ISSUE && phy_cmd_code == dms_pkg::CMD_SRX)))
        else $error("self-refresh ack wrong");
    dpd_ack_state_a: assert property (dpd_ack == (state == dms_pkg::ST_DEEP_PD
        || (state == dms_pkg::ST_ISSUE && phy_cmd_code == dms_pkg::CMD_DPDX)))
        else $error("deep power down ack wrong");
    mr_busy_span_a: assert property (mr_busy |-> phy_cmd_code == dms_pkg::CMD_MRS
        && (state == dms_pkg::ST_ISSUE || state == dms_pkg::ST_WAIT))
        else $error("mode register busy outside command");
    ref_ack_rise_a: assert property (state == dms_pkg::ST_ISSUE && phy_cmd_ready
        && phy_cmd_code == dms_pkg::CMD_REF |=> ref_ack && tmr.busy)
        else $error("refresh ack late");
    zq_ack_fall_a: assert property (state == dms_pkg::ST_WAIT && !tmr.busy
        |=> !zq_ack && !ref_ack && state == dms_pkg::ST_IDLE)
        else $error("ack outlived interval");
    ref_clear_a: assert property (state == dms_pkg::ST_WAIT && !tmr.busy && !wr_fire
        && phy_cmd_code == dms_pkg::CMD_REF |=> (ref_req & phy_cmd_rank) == 4'h0)
        else $error("refresh bit not cleared");
    apd_follow_a: assert property ($rose(auto_pd_state) |=> apd_ack)
        else $error("auto power down ack late");

    sr_entry_c: cover property (state == dms_pkg::ST_SELF_REFRESH);
    dpd_entry_c: cover property (state == dms_pkg::ST_DEEP_PD);
    mr_done_c: cover property (clr_mr);
    ref_done_c: cover property (clr_ref != 4'h0);
endmodule : dms_sideband

// ===== core/dms_pkg.sv
// Constants and types for the DRAM maintenance sideband block.
// Assumes a 32-bit AXI4-Lite register port with 4-byte aligned registers.
package dms_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned RANKS = 4;
    localparam int unsigned TIME_W = 8;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_MR_GO = 6'h2b;
    localparam logic [5:0] IDX_REFRESH_REQ = 6'h2c;
    localparam logic [5:0] IDX_ZQ_LONG = 6'h2d;
    localparam logic [5:0] IDX_ZQ_SHORT = 6'h2e;
    localparam logic [5:0] IDX_SELF_REFRESH = 6'h2f;
    localparam logic [5:0] IDX_DEEP_PD = 6'h30;
    localparam logic [5:0] IDX_MR_PROGRESS = 6'h31;
    localparam logic [5:0] IDX_REF_PROGRESS = 6'h32;
    localparam logic [5:0] IDX_ZQ_PROGRESS = 6'h33;
    localparam logic [5:0] IDX_SR_PROGRESS = 6'h34;
    localparam logic [5:0] IDX_DPD_PROGRESS = 6'h35;
    localparam logic [5:0] IDX_APD_PROGRESS = 6'h36;
    localparam logic [5:0] IDX_TIMING = 6'h3c;

    // Interval fields of the timing register, counted in clock cycles
    localparam int unsigned REF_INTERVAL_LSB = 0;
    localparam int unsigned ZQ_LONG_LSB = 8;
    localparam int unsigned ZQ_SHORT_LSB = 16;
    localparam int unsigned MR_INTERVAL_LSB = 24;
    localparam logic [31:0] TIMING_RESET = 32'h08_40_80_20;

    localparam logic [3:0] RANKS_ALL = 4'hf;
    localparam logic [3:0] RANKS_NONE = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        CMD_REF, CMD_ZQCL, CMD_ZQCS, CMD_MRS, CMD_SRE, CMD_SRX, CMD_DPDE, CMD_DPDX
    } dms_cmd_type;

    typedef enum {
        ST_IDLE, ST_ISSUE, ST_WAIT, ST_SELF_REFRESH, ST_DEEP_PD
    } dms_state_type;
endpackage : dms_pkg

// ===== core/dms_timer_if.sv
// Link between the sequencer and its interval timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface dms_timer_if;
    logic start;
    logic [dms_pkg::TIME_W-1:0] length;
    logic busy;
    modport timer (input start, input length, output busy);
    modport user (output start, output length, input busy);
endinterface : dms_timer_if

// ===== core/dms_interval_timer.sv
// Countdown timer that holds busy for a programmed number of cycles.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ns
module dms_interval_timer (
    input wire logic aclk,
    input wire logic aresetn,
    dms_timer_if.timer tmr
);
    logic [dms_pkg::TIME_W-1:0] count;
    logic [dms_pkg::TIME_W-1:0] next_count;
    logic next_busy;

    // Zero length still gives one busy cycle so the sequencer never hangs
    always_comb begin
        next_count = count;
        if (tmr.start) begin
            next_count = (tmr.length == '0) ? dms_pkg::TIME_W'(1) : tmr.length;
        end else if (count != '0) begin
            next_count = count - dms_pkg::TIME_W'(1);
        end
        next_busy = (next_count != '0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            tmr.busy <= 1'b0;
        end else begin
            count <= next_count;
            tmr.busy <= next_busy;
        end
    end

    timer_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tmr.start |=> tmr.busy) else $error("timer not busy after start");
endmodule : dms_interval_timer

// ===== bench/dms_phy_model.sv
// PHY stand-in that takes sideband commands.
// Assumes the command port shares aclk with the block.
`timescale 1ns/1ns
module dms_phy_model (
    input wire logic aclk,
    input wire logic cmd_valid,
    input wire logic [2:0] stall,
    output logic cmd_ready
);
    logic [2:0] cnt = 3'h0;
    // Stall a set number of cycles, then take one command
    always @(posedge aclk) begin
        cmd_ready <= cmd_valid && cnt == stall && !cmd_ready;
        cnt <= (cmd_valid && !cmd_ready && cnt != stall) ? cnt + 3'h1 : 3'h0;
    end
endmodule : dms_phy_model

// ===== bench/testbench.sv
// Bench for the maintenance sideband over AXI4-Lite with a PHY stand-in.
// Assumes dms_pkg, the design and dms_phy_model are compiled first.
`timescale 1ns/1ns
module testbench;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, apd = 1'h0, awready, wready, bvalid;
    logic arready, rvalid, cv, cr;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rd_v;
    logic [1:0] bresp, rresp, rsp;
    logic [3:0] rank, last_rank;
    logic [2:0] stall = 3'h0;
    dms_pkg::dms_cmd_type code, last_code;
    int miscompares = 0, cmp_count = 0;
    dms_sideband dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .phy_cmd_valid(cv), .phy_cmd_code(code),
        .phy_cmd_rank(rank), .phy_cmd_ready(cr), .auto_pd_state(apd));
    dms_phy_model phy (.aclk(aclk), .cmd_valid(cv), .stall(stall), .cmd_ready(cr));
    // 50 MHz clock
    always #10 aclk = ~aclk;
    // Last command the PHY took
    always @(posedge aclk) if (cv && cr) begin
        last_code <= code;
        last_rank <= rank;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic a, w;
        a = 1'h1;
        w = 1'h1;
        awaddr <= {idx, 2'h0};
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (a || w) begin
            @(posedge aclk);
            if (awready) a = 1'h0;
            if (wready) w = 1'h0;
            awvalid <= a;
            wvalid <= w;
        end
        while (bvalid !== 1'h1) @(posedge aclk);
        bready <= 1'h0;
        rsp = bresp;
        // Let an edge pass so a following call never reassigns bready now
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [5:0] idx);
        araddr <= {idx, 2'h0};
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge aclk);
        rready <= 1'h0;
        rd_v = rdata;
        rsp = rresp;
        // Let an edge pass so a following call never reassigns rready now
        @(posedge aclk);
    endtask : rd
    // Read up to n times until the value shows, then judge it
    task automatic poll(input logic [5:0] idx, input logic [31:0] e, input int n);
        rd_v = ~e;
        for (int i = 0; i < n && rd_v !== e; i++) rd(idx);
        check(rd_v, e);
    endtask : poll
    task automatic t_regs;
        poll(dms_pkg::IDX_TIMING, dms_pkg::TIMING_RESET, 1);
        wr(dms_pkg::IDX_ZQ_PROGRESS, 32'h1);
        poll(dms_pkg::IDX_ZQ_PROGRESS, 32'h0, 1);
        wr(6'h3f, 32'h1);
        check({30'h0, rsp}, {30'h0, dms_pkg::RESP_DECERR});
        rd(6'h3f);
        check({30'h0, rsp}, {30'h0, dms_pkg::RESP_DECERR});
        wr(dms_pkg::IDX_TIMING, 32'h10408020);
        $display("register test done");
    endtask : t_regs
    // Self-clearing request, each with a slower PHY than the last
    task automatic t_pulse(input logic [5:0] ri, input logic [3:0] v, input logic [5:0] pi,
            input dms_pkg::dms_cmd_type c, input logic [3:0] rk);
        wr(ri, {28'h0, v});
        poll(pi, 32'h1, 20);
        // Mode register busy shows before the PHY takes it, so judge the code later
        poll(ri, 32'h0, 100);
        check({29'h0, last_code}, {29'h0, c});
        check({28'h0, last_rank}, {28'h0, rk});
        poll(pi, 32'h0, 1);
        stall <= stall + 3'h1;
        $display("pulse test done");
    endtask : t_pulse
    task automatic t_hold(input logic [5:0] ri, input logic [3:0] v, input logic [5:0] pi,
            input dms_pkg::dms_cmd_type c_in, input dms_pkg::dms_cmd_type c_out);
        wr(ri, {28'h0, v});
        poll(pi, 32'h1, 20);
        check({29'h0, last_code}, {29'h0, c_in});
        poll(ri, {28'h0, v}, 1);
        wr(ri, 32'h0);
        poll(pi, 32'h0, 20);
        check({29'h0, last_code}, {29'h0, c_out});
        $display("hold test done");
    endtask : t_hold
    task automatic t_apd;
        apd <= 1'h1;
        poll(dms_pkg::IDX_APD_PROGRESS, 32'h1, 3);
        apd <= 1'h0;
        poll(dms_pkg::IDX_APD_PROGRESS, 32'h0, 3);
        $display("auto power down test done");
    endtask : t_apd
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // Main sequence after 16 reset cycles
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs;
        t_pulse(dms_pkg::IDX_ZQ_LONG, 4'h1, dms_pkg::IDX_ZQ_PROGRESS, dms_pkg::CMD_ZQCL, 4'hf);
        t_pulse(dms_pkg::IDX_ZQ_SHORT, 4'h1, dms_pkg::IDX_ZQ_PROGRESS, dms_pkg::CMD_ZQCS, 4'hf);
        t_pulse(dms_pkg::IDX_REFRESH_REQ, 4'h4, dms_pkg::IDX_REF_PROGRESS, dms_pkg::CMD_REF, 4'h4);
        t_pulse(dms_pkg::IDX_MR_GO, 4'h1, dms_pkg::IDX_MR_PROGRESS, dms_pkg::CMD_MRS, 4'hf);
        t_hold(dms_pkg::IDX_SELF_REFRESH, 4'hf, dms_pkg::IDX_SR_PROGRESS, dms_pkg::CMD_SRE,
            dms_pkg::CMD_SRX);
        t_hold(dms_pkg::IDX_DEEP_PD, 4'h1, dms_pkg::IDX_DPD_PROGRESS, dms_pkg::CMD_DPDE,
            dms_pkg::CMD_DPDX);
        t_apd;
        finish_test;
    end
    // Watchdog well past the few hundred cycles the tests need
    initial begin
        #400000;
        miscompares++;
        finish_test;
    end
endmodule : testbench
